// [design/lpm_pkg.sv]
// Package for the low-power mode sequencer: modes, states and timing counts.
// Assumes a single 125 MHz clock and an active-low asynchronous reset.
package lpm_pkg;
  // Oscillator ticks per machine cycle, and strobe high phase within it
  localparam int unsigned OscPerCycle   = 6;
  localparam logic [2:0]  CycleLast     = 3'h5;
  localparam logic [2:0]  StrobeHiPhase = 3'h1;
  // Reset must be seen high this many machine cycles
  localparam logic [1:0]  RstCycles     = 2'h2;
  // Resumed cycles allowed after reset ends idle
  localparam logic [1:0]  ResumeCycles  = 2'h2;
  // Oscillator settle time (ms) and core-clock count for the host end
  localparam int unsigned SettleMs      = 10;
  localparam int unsigned ClockMhz      = 125;
  localparam int unsigned SettleCycles  = SettleMs * 1000 * ClockMhz;

  typedef enum logic [2:0] {
    LPM_RUN    = 3'h0,
    LPM_IDLE   = 3'h1,
    LPM_RESUME = 3'h3,
    LPM_PDOWN  = 3'h2,
    LPM_WAKE   = 3'h6,
    LPM_EMUL   = 3'h4
  } lpm_state_t;
endpackage

// [design/lpm_if.sv]
// Link between the mode sequencer and the board-side party.
// Assumes both ends share the clock; the bench resolves weak pull-ups.
`timescale 1ns/1ps
interface lpm_if (
  input wire logic clock,
  input wire logic nrst
);
  logic rstPin;        // Board reset, active high
  logic extIrqZeroN;   // External interrupt zero, active low
  logic extIrqOneN;    // External interrupt one, active low
  logic latchStrobeI;  // Address latch strobe as seen on the wire
  logic latchStrobeO;
  logic latchStrobeOeN;
  logic latchStrobeDrvI; // Board drive of latch strobe
  logic latchStrobeDrvOeN;
  logic fetchStrobeN;  // Program fetch strobe, active low
  logic busPortZeroFloat;
  logic busPortTwoAddr;
  logic oscRun;
  logic emulMode;
  modport dev (input rstPin, extIrqZeroN, extIrqOneN, latchStrobeI,
               output latchStrobeO, latchStrobeOeN, fetchStrobeN,
               busPortZeroFloat, busPortTwoAddr, oscRun, emulMode);
  modport brd (output rstPin, extIrqZeroN, extIrqOneN, latchStrobeDrvI,
               latchStrobeDrvOeN,
               input latchStrobeI, fetchStrobeN, oscRun, emulMode);
endinterface

// [design/lpm_board.sv]
// Board-side end: reset, wake interrupt and emulation entry on the strobes.
// Assumes the bench forms latchStrobeI from both ends' drives.
`timescale 1ns/1ps
module lpm_board #(
  parameter int unsigned HoldCycles = lpm_pkg::SettleCycles
) (
  input  wire logic clock,
  input  wire logic nrst,
  lpm_if.brd        link,
  input  wire logic resetReq,
  input  wire logic wakeReq,
  input  wire logic emulReq,
  output logic      busy
);
  logic [31:0] cnt_q;
  logic        rst_q;
  logic        irqN_q;
  logic        lsOeN_q;
  logic        emulArm_q;
  logic        busy_q;
  logic [1:0]  op_q;     // 0 none, 1 reset, 2 wake
  logic [31:0] holdEnd;
  logic [31:0] doneEnd;

  // Hold span cut to the counter width; a bench may shorten it to keep runs brief
  assign holdEnd = HoldCycles[31:0];
  assign doneEnd = holdEnd + 32'h8;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= 32'h0;
      op_q      <= 2'h0;
      rst_q     <= 1'b0;
      irqN_q    <= 1'b1;
      emulArm_q <= 1'b0;
      busy_q    <= 1'b0;
    end else if (op_q == 2'h0) begin
      if (resetReq || wakeReq) begin
        op_q      <= resetReq ? 2'h1 : 2'h2;
        rst_q     <= resetReq;
        irqN_q    <= resetReq;
        emulArm_q <= resetReq && emulReq;
        busy_q    <= 1'b1;
        cnt_q     <= 32'h0;
      end
    end else if (cnt_q >= holdEnd) begin
      rst_q  <= 1'b0;
      irqN_q <= 1'b1;
      // Strobe strap outlives reset release by a few cycles
      if (cnt_q >= doneEnd) begin
        op_q      <= 2'h0;
        emulArm_q <= 1'b0;
        busy_q    <= 1'b0;
      end
      cnt_q <= cnt_q + 32'h1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // Strobe low through reset
  // Pulled only once the fetch strobe reads high, then held across release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lsOeN_q <= 1'b1;
    else if (!emulArm_q) lsOeN_q <= 1'b1;
    else if (rst_q && link.fetchStrobeN) lsOeN_q <= 1'b0;
  end

  assign link.rstPin            = rst_q;
  assign link.extIrqZeroN       = irqN_q;
  assign link.extIrqOneN        = 1'b1;
  assign link.latchStrobeDrvI   = 1'b0;
  assign link.latchStrobeDrvOeN = lsOeN_q;
  assign busy                   = busy_q;
endmodule

// [design/lpm_device.sv]
// Device end: clock divide, machine-cycle strobe, idle, power-down, emulation.
// Assumes the core holds its requests one clock and keeps level interrupt setup.
`timescale 1ns/1ps
module lpm_device (
  input  wire logic clock,
  input  wire logic nrst,
  lpm_if.dev        link,
  input  wire logic idleReq,
  input  wire logic pdownReq,
  input  wire logic irqPending,
  input  wire logic irqZeroEn,
  input  wire logic irqOneEn,
  input  wire logic irqLevelMode,
  input  wire logic extProgMem,
  output logic      coreRun,
  output logic      periphRun,
  output logic      ramBlock,
  output logic      regInit,
  output logic      wakeIrq
);
  lpm_pkg::lpm_state_t state_q;
  logic        half_q;
  logic [2:0]  phase_q;
  logic [1:0]  rstCnt_q;
  logic        rstValid_q;
  logic [1:0]  resume_q;
  logic        lsO_q;
  logic        fsN_q;
  logic        lsOeN_q;
  logic        p0Float_q;
  logic        p2Addr_q;
  logic        osc_q;
  logic        emul_q;
  logic        coreRun_q;
  logic        periph_q;
  logic        ramBlock_q;
  logic        regInit_q;
  logic        wakeIrq_q;
  logic        tick;
  logic        cycEnd;
  logic        wakeLow;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) half_q <= 1'b0;
    else if (osc_q) half_q <= !half_q;
  end
  assign tick   = osc_q && half_q;
  assign cycEnd = tick && (phase_q == lpm_pkg::CycleLast);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) phase_q <= 3'h0;
    else if (tick) phase_q <= cycEnd ? 3'h0 : phase_q + 3'h1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstCnt_q   <= 2'h0;
      rstValid_q <= 1'b0;
    end else if (!link.rstPin) begin
      rstCnt_q   <= 2'h0;
      rstValid_q <= 1'b0;
    end else if (cycEnd && rstCnt_q != lpm_pkg::RstCycles) begin
      rstCnt_q <= rstCnt_q + 2'h1;
    end else if (rstCnt_q == lpm_pkg::RstCycles) begin
      rstValid_q <= 1'b1;
    end
  end

  // Wake needs an enabled, level-mode external line held low
  // Level-mode wake only
  assign wakeLow = irqLevelMode &&
                   ((irqZeroEn && !link.extIrqZeroN) || (irqOneEn && !link.extIrqOneN));

  // Mode sequencer; register and RAM contents live outside and are only gated here
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q    <= lpm_pkg::LPM_RUN;
      resume_q   <= 2'h0;
      osc_q      <= 1'b1;
      emul_q     <= 1'b0;
      regInit_q  <= 1'b1;
      wakeIrq_q  <= 1'b0;
    end else begin
      wakeIrq_q <= 1'b0;
      regInit_q <= 1'b0;
      case (state_q)
        lpm_pkg::LPM_RUN: begin
          if (rstValid_q) begin
            regInit_q <= 1'b1;
            if (!link.latchStrobeI && fsN_q) emul_q <= 1'b1;
          end else if (pdownReq) begin
            osc_q   <= 1'b0;
            state_q <= lpm_pkg::LPM_PDOWN;
          end else if (idleReq) begin
            state_q <= lpm_pkg::LPM_IDLE;
          end
          if (emul_q && !link.rstPin) state_q <= lpm_pkg::LPM_EMUL;
        end
        lpm_pkg::LPM_IDLE: begin
          if (link.rstPin) begin
            resume_q <= 2'h0;
            state_q  <= lpm_pkg::LPM_RESUME;
          end else if (irqPending) begin
            state_q <= lpm_pkg::LPM_RUN;
          end
        end
        lpm_pkg::LPM_RESUME: begin
          if (rstValid_q || resume_q == lpm_pkg::ResumeCycles) begin
            state_q <= lpm_pkg::LPM_RUN;
          end else if (cycEnd) begin
            resume_q <= resume_q + 2'h1;
          end
        end
        lpm_pkg::LPM_PDOWN: begin
          if (link.rstPin || wakeLow) begin
            osc_q   <= 1'b1;
            state_q <= lpm_pkg::LPM_WAKE;
          end
        end
        lpm_pkg::LPM_WAKE: begin
          if (rstValid_q) begin
            regInit_q <= 1'b1;
            state_q   <= lpm_pkg::LPM_RUN;
          end else if (!link.rstPin && link.extIrqZeroN && link.extIrqOneN) begin
            wakeIrq_q <= 1'b1;
            state_q   <= lpm_pkg::LPM_RUN;
          end
        end
        lpm_pkg::LPM_EMUL: begin
          if (rstValid_q && link.latchStrobeI) begin
            emul_q    <= 1'b0;
            regInit_q <= 1'b1;
            state_q   <= lpm_pkg::LPM_RUN;
          end
        end
        default: state_q <= lpm_pkg::LPM_RUN;
      endcase
    end
  end

  // Core, peripheral and RAM gating
  // Contents frozen by clock gating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      coreRun_q  <= 1'b0;
      periph_q   <= 1'b1;
      ramBlock_q <= 1'b0;
    end else begin
      coreRun_q  <= (state_q == lpm_pkg::LPM_RUN && !link.rstPin) ||
                    state_q == lpm_pkg::LPM_RESUME;
      periph_q   <= state_q != lpm_pkg::LPM_PDOWN && state_q != lpm_pkg::LPM_WAKE;
      ramBlock_q <= state_q == lpm_pkg::LPM_RESUME;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lsO_q     <= 1'b1;
      lsOeN_q   <= 1'b1;
      fsN_q     <= 1'b1;
      p0Float_q <= 1'b1;
      p2Addr_q  <= 1'b0;
    end else begin
      lsOeN_q   <= 1'b0;
      p0Float_q <= extProgMem;
      p2Addr_q  <= extProgMem;
      fsN_q     <= !(extProgMem && tick && phase_q[0]);
      lsO_q     <= phase_q == lpm_pkg::StrobeHiPhase;
      case (state_q)
        lpm_pkg::LPM_IDLE: begin
          lsO_q <= 1'b1;
          fsN_q <= 1'b1;
        end
        lpm_pkg::LPM_PDOWN, lpm_pkg::LPM_WAKE: begin
          lsO_q    <= 1'b0;
          fsN_q    <= 1'b0;
          p2Addr_q <= 1'b0;
        end
        lpm_pkg::LPM_EMUL: begin
          lsOeN_q   <= 1'b1;
          fsN_q     <= 1'b1;
          p0Float_q <= 1'b1;
          p2Addr_q  <= 1'b0;
        end
        default: begin
          // Let board strap during reset; fetch strobe rests high so a strap can be seen
          if (link.rstPin) begin
            lsOeN_q <= 1'b1;
            fsN_q   <= 1'b1;
          end
        end
      endcase
    end
  end

  assign link.latchStrobeO     = lsO_q;
  assign link.latchStrobeOeN   = lsOeN_q;
  assign link.fetchStrobeN     = fsN_q;
  assign link.busPortZeroFloat = p0Float_q;
  assign link.busPortTwoAddr   = p2Addr_q;
  assign link.oscRun           = osc_q;
  assign link.emulMode         = emul_q;
  assign coreRun               = coreRun_q;
  assign periphRun             = periph_q;
  assign ramBlock              = ramBlock_q;
  assign regInit               = regInit_q;
  assign wakeIrq               = wakeIrq_q;
endmodule

// [tb/lpm_assertions.sv]
// Checker for the mode sequencer link: pin states per mode and exits.
// Assumes it is instantiated beside the link that joins both ends.
`timescale 1ns/1ps
module lpm_assertions (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rstPin,
  input wire logic extIrqZeroN,
  input wire logic extIrqOneN,
  input wire logic latchStrobeI,
  input wire logic latchStrobeDrvOeN,
  input wire logic fetchStrobeN,
  input wire logic busPortZeroFloat,
  input wire logic busPortTwoAddr,
  input wire logic oscRun,
  input wire logic emulMode
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  pdn_strobe_low_a: assert property ($fell(oscRun) |=> !latchStrobeI && !fetchStrobeN)
    else $error("strobes not low after oscillator stop");
  pdn_hold_low_a: assert property (
    !oscRun && !$past(oscRun) |-> !latchStrobeI && !fetchStrobeN)
    else $error("strobes left low state in power-down");
  pdn_port_data_a: assert property ($fell(oscRun) |=> !busPortTwoAddr)
    else $error("port two still on address in power-down");
  pdn_stays_a: assert property (
    !oscRun && !rstPin && extIrqZeroN && extIrqOneN |=> !oscRun)
    else $error("power-down left without reset or interrupt");
  rst_restart_a: assert property (!oscRun && rstPin |-> ##[1:4] oscRun)
    else $error("reset did not restart oscillator");
  wake_by_pin_a: assert property (
    $rose(oscRun) && !rstPin |-> !extIrqZeroN || !extIrqOneN)
    else $error("oscillator restarted without a low wake pin");
  emul_float_a: assert property (emulMode |-> busPortZeroFloat && oscRun)
    else $error("emulation port zero or oscillator wrong");
  emul_pullup_a: assert property (
    emulMode && latchStrobeDrvOeN |-> latchStrobeI && fetchStrobeN)
    else $error("emulation strobes not high");
  emul_stays_a: assert property (emulMode && !rstPin |=> emulMode)
    else $error("emulation left without reset");
endmodule

// [tb/testbench.sv]
// Self-checking bench: both ends joined by the link, core and board sides driven here.
// Assumes the board end sequences reset, wake and emulation entry on its own.
`timescale 1ns/1ps
module testbench;
  // Board hold cut far below the real settle time to keep the run short
  localparam int unsigned BenchHold = 64;
  // Two machine cycles of six divided ticks, plus two pipeline edges
  localparam int ResumeMax = 2 * 2 * lpm_pkg::OscPerCycle + 2;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic idleReq = 1'b0, pdownReq = 1'b0, irqPending = 1'b0;
  logic resetReq = 1'b0, wakeReq = 1'b0, emulReq = 1'b0;
  logic levelMode = 1'b1, extMem = 1'b1;
  logic coreRun, periphRun, ramBlock, regInit, wakeIrq, busy;
  int   initCnt = 0, wakeCnt = 0, blockCnt = 0;
  int   errCount = 0;
  int   nTests = 0;

  always #4 clock = ~clock;

  lpm_if link (.clock(clock), .nrst(nrst));
  // Wire level: board drive wins, then device drive, else weak pull-up
  assign link.latchStrobeI = !link.latchStrobeDrvOeN ? link.latchStrobeDrvI :
                             (!link.latchStrobeOeN ? link.latchStrobeO : 1'b1);

  lpm_device lpm_device_i (.clock(clock), .nrst(nrst), .link(link), .idleReq(idleReq),
    .pdownReq(pdownReq), .irqPending(irqPending), .irqZeroEn(1'b1), .irqOneEn(1'b1),
    .irqLevelMode(levelMode), .extProgMem(extMem), .coreRun(coreRun), .periphRun(periphRun),
    .ramBlock(ramBlock), .regInit(regInit), .wakeIrq(wakeIrq));
  lpm_board #(.HoldCycles(BenchHold)) lpm_board_i (.clock(clock), .nrst(nrst), .link(link),
    .resetReq(resetReq), .wakeReq(wakeReq), .emulReq(emulReq), .busy(busy));
  lpm_assertions lpm_assertions_i (.clock(clock), .nrst(nrst), .rstPin(link.rstPin),
    .extIrqZeroN(link.extIrqZeroN), .extIrqOneN(link.extIrqOneN),
    .latchStrobeI(link.latchStrobeI), .latchStrobeDrvOeN(link.latchStrobeDrvOeN),
    .fetchStrobeN(link.fetchStrobeN), .busPortZeroFloat(link.busPortZeroFloat),
    .busPortTwoAddr(link.busPortTwoAddr), .oscRun(link.oscRun), .emulMode(link.emulMode));

  // Counters, since wakeIrq stands one cycle and regInit ends with reset; tasks compare snapshots
  always @(posedge clock) begin
    if (regInit === 1'b1) initCnt <= initCnt + 1;
    if (wakeIrq === 1'b1) wakeCnt <= wakeCnt + 1;
    if (ramBlock === 1'b1) blockCnt <= blockCnt + 1;
  end

  task automatic check(input logic got, input logic exp, input string msg);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t %s: got %b want %b", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One-cycle request launched at a rising edge: bit 0 idle, 1 power-down, 2 wake, 3 reset
  task automatic pulse(input logic [3:0] sel);
    @(posedge clock) begin
      idleReq  <= sel[0];
      pdownReq <= sel[1];
      wakeReq  <= sel[2];
      resetReq <= sel[3];
    end
    @(posedge clock) begin
      idleReq  <= 1'b0;
      pdownReq <= 1'b0;
      wakeReq  <= 1'b0;
      resetReq <= 1'b0;
    end
  endtask

  // A board sequence lasts the shortened hold plus a few cycles
  task automatic wait_board();
    int i;
    tick(2);
    for (i = 0; i < 2000 && busy !== 1'b0; i++) tick(1);
    check(busy, 1'b0, "board stuck busy");
    tick(40);
  endtask

  task automatic test_idle();
    // No port or memory write follows the idle request
    pulse(4'h1);
    tick(4);
    check(coreRun, 1'b0, "idle core");
    check(periphRun, 1'b1, "idle peripherals");
    check(link.latchStrobeI, 1'b1, "idle latch");
    check(link.fetchStrobeN, 1'b1, "idle fetch");
    check(link.busPortTwoAddr, 1'b1, "idle bus_port_two");
    check(link.busPortZeroFloat, 1'b1, "idle bus_port_zero");
    @(posedge clock) irqPending <= 1'b1;
    tick(6);
    check(coreRun, 1'b1, "irq ends idle");
    @(posedge clock) irqPending <= 1'b0;
    $display("test idle done");
  endtask

  // Both requests together: power-down must take precedence
  task automatic test_pdown_irq();
    int w0;
    int i0;
    pulse(4'h3);
    tick(4);
    check(link.oscRun, 1'b0, "pdown wins");
    check(coreRun, 1'b0, "pdown core");
    check(link.busPortTwoAddr, 1'b0, "pdown bus_port_two");
    tick(30);
    check(link.oscRun, 1'b0, "pdown holds");
    w0 = wakeCnt;
    i0 = initCnt;
    pulse(4'h4);
    wait_board();
    check(wakeCnt != w0, 1'b1, "wake pulse");
    check(initCnt != i0, 1'b0, "irq keeps registers");
    check(coreRun, 1'b1, "resume after wake");
    $display("test pdown irq done");
  endtask

  task automatic test_pdown_reset();
    int i0;
    pulse(4'h2);
    tick(4);
    check(link.oscRun, 1'b0, "pdown entered");
    i0 = initCnt;
    pulse(4'h8);
    wait_board();
    check(initCnt != i0, 1'b1, "reset reinit");
    check(link.oscRun, 1'b1, "osc restarted");
    $display("test pdown reset done");
  endtask

  // Reset ends idle with internal program memory: short resumed window, RAM blocked
  task automatic test_idle_reset();
    int b0;
    int i0;
    @(posedge clock) extMem <= 1'b0;
    pulse(4'h1);
    tick(4);
    check(link.busPortTwoAddr, 1'b0, "idle bus_port_two internal");
    check(link.busPortZeroFloat, 1'b0, "idle bus_port_zero internal");
    b0 = blockCnt;
    i0 = initCnt;
    pulse(4'h8);
    wait_board();
    check(blockCnt != b0, 1'b1, "resume blocks RAM");
    check(blockCnt - b0 <= ResumeMax, 1'b1, "resume too long");
    check(ramBlock, 1'b0, "RAM open after reset");
    check(initCnt != i0, 1'b1, "reset ends idle");
    @(posedge clock) extMem <= 1'b1;
    $display("test idle reset done");
  endtask

  // Edge-mode interrupts must not end power-down; reset then ends it with level mode set again
  task automatic test_edge_mode();
    @(posedge clock) levelMode <= 1'b0;
    pulse(4'h2);
    tick(4);
    pulse(4'h4);
    wait_board();
    check(link.oscRun, 1'b0, "edge mode no wake");
    @(posedge clock) levelMode <= 1'b1;
    pulse(4'h8);
    wait_board();
    check(link.oscRun, 1'b1, "reset leaves pdown");
    $display("test edge mode done");
  endtask

  task automatic test_emul();
    @(posedge clock) emulReq <= 1'b1;
    pulse(4'h8);
    wait_board();
    @(posedge clock) emulReq <= 1'b0;
    tick(20);
    check(link.emulMode, 1'b1, "emul entered");
    check(link.busPortZeroFloat, 1'b1, "emul bus_port_zero");
    check(link.oscRun, 1'b1, "emul osc");
    pulse(4'h8);
    wait_board();
    check(link.emulMode, 1'b0, "emul left");
    $display("test emulation done");
  endtask

  task automatic print_verdict();
    $display("tests %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    tick(3);
    test_idle();
    test_pdown_irq();
    test_pdown_reset();
    test_idle_reset();
    test_edge_mode();
    test_emul();
    print_verdict();
  end

  // Watchdog: the tests need about a thousand cycles, so this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clock);
    errCount++;
    print_verdict();
  end
endmodule
